// ==== shared/sdp_pkg.sv ====
// What this block does
// - tap state advances on sampled mode select
// - serial input sampled on test clock rise
// - serial output driven only while shifting out
// - test reset clears interface logic asynchronously
// - serial logic paced by test clock edges
// - instruction register cpu read-only, never shifted out
// - last four instruction bits shifted are kept
// - test reset loads all-ones instruction
// - status readable serially, never loaded serially
// - status shifts out flag first, reserved next
// - status bit 11 one, other reserved zero
// - flag zero means cpu owns data word
// - test reset sets transfer flag to one
// - data word: two cpu-accessible halves, serial chain
// - data shifts keep the last 32 bits
// - input enters high bit 31, output low bit 0
// - data word never reset by anything
// - one-bit bypass stage, no cpu access
// - loading interrupt instruction raises interrupt request
// - all-ones instruction routes input through bypass stage
// - five mode-select-high clocks reset the interface
// - serial output changes on test clock rise
package sdp_pkg;
  localparam int SDP_REG_W = 16;
  localparam int SDP_DATA_W = 32;
  localparam int SDP_INSTR_W = 4;
  localparam int SDP_SEL_W = 2;
  // instruction codes
  localparam logic [SDP_INSTR_W-1:0] SDP_INSTR_IRQ = 4'hA;
  localparam logic [SDP_INSTR_W-1:0] SDP_INSTR_BYPASS = 4'hF;
  localparam logic [SDP_INSTR_W-1:0] SDP_INSTR_RESET = 4'hF;
  localparam logic [11:0] SDP_INSTR_PAD = 12'h000;
  // status layout: bits 15..1 constant, bit 0 transfer flag
  localparam logic [14:0] SDP_STAT_FIXED = 15'h0400;
  localparam int SDP_FLAG_BIT = 0;
  localparam logic SDP_FLAG_RESET = 1'b1;
  // cpu register selects
  localparam logic [SDP_SEL_W-1:0] SDP_SEL_INSTR = 2'h0;
  localparam logic [SDP_SEL_W-1:0] SDP_SEL_STATUS = 2'h1;
  localparam logic [SDP_SEL_W-1:0] SDP_SEL_DATA_HI = 2'h2;
  localparam logic [SDP_SEL_W-1:0] SDP_SEL_DATA_LO = 2'h3;
  // consecutive mode-select-high edges that force reset
  localparam logic [2:0] SDP_TMS_RESET_CNT = 3'h5;
  typedef enum logic [3:0] {
    SDP_TLR, SDP_RTI, SDP_SEL_DR, SDP_CAP_DR, SDP_SH_DR, SDP_EX1_DR,
    SDP_PA_DR, SDP_EX2_DR, SDP_UPD_DR, SDP_SEL_IR, SDP_CAP_IR,
    SDP_SH_IR, SDP_EX1_IR, SDP_PA_IR, SDP_EX2_IR, SDP_UPD_IR
  } sdp_tap_t;
endpackage : sdp_pkg

// ==== rtl/sdp_debug_port.sv ====
`timescale 1ns/100ps
module sdp_debug_port (
  input wire logic I_CORE_CLK,
  input wire logic I_RSTN,
  input wire logic I_TRST_N,
  input wire logic I_TCK,
  input wire logic I_TMS,
  input wire logic I_TDI,
  output logic O_TDO,
  output logic O_TDO_OE,
  output logic O_IRQ,
  input wire logic [sdp_pkg::SDP_SEL_W-1:0] I_CPU_SEL,
  input wire logic I_CPU_WE,
  input wire logic [sdp_pkg::SDP_REG_W-1:0] I_CPU_WDATA,
  output logic [sdp_pkg::SDP_REG_W-1:0] O_CPU_RDATA,
  output logic O_CPU_FLAG
);
  import sdp_pkg::*;

  typedef struct packed {
    logic tck_s1;
    logic tck_s2;
    logic tck_s3;
    logic tms_s1;
    logic tms_s2;
    logic tdi_s1;
    logic tdi_s2;
    sdp_tap_t state;
    logic [SDP_INSTR_W-1:0] ir_sh;
    logic [SDP_INSTR_W-1:0] instr;
    logic flag;
    logic [SDP_REG_W-1:0] stat_sh;
    logic bypass;
    logic tdo;
    logic tdo_oe;
    logic irq;
    logic [SDP_REG_W-1:0] rdata;
    logic [2:0] tms_hi;
  } sdp_state_t;

  sdp_state_t q, n;
  logic [SDP_DATA_W-1:0] data_q;
  logic [SDP_DATA_W-1:0] data_d;
  logic rst_n;
  logic tck_rise;
  logic data_sel;
  logic [SDP_REG_W-1:0] status_word;

  // either reset clears the interface at once
  // asynchronous test reset
  assign rst_n = I_RSTN & I_TRST_N;
  // test clock edge found by core clock
  assign tck_rise = q.tck_s2 & ~q.tck_s3;
  // data word owns the chain under the interrupt instruction while flag shows transfer in progress
  assign data_sel = (q.instr == SDP_INSTR_IRQ) && q.flag;
  assign status_word = {SDP_STAT_FIXED, q.flag};

  // next state of all control logic
  always_comb begin
    n = q;
    data_d = data_q;
    n.tck_s1 = I_TCK;
    n.tck_s2 = q.tck_s1;
    n.tck_s3 = q.tck_s2;
    n.tms_s1 = I_TMS;
    n.tms_s2 = q.tms_s1;
    n.tdi_s1 = I_TDI;
    n.tdi_s2 = q.tdi_s1;
    n.irq = 1'b0;
    // cpu read mux, one cycle latency
    // instruction readable, low bits zero
    case (I_CPU_SEL)
      SDP_SEL_INSTR: n.rdata = {q.instr, SDP_INSTR_PAD};
      SDP_SEL_STATUS: n.rdata = status_word;
      SDP_SEL_DATA_HI: n.rdata = data_q[SDP_DATA_W-1:SDP_REG_W];
      SDP_SEL_DATA_LO: n.rdata = data_q[SDP_REG_W-1:0];
      default: n.rdata = status_word;
    endcase
    // cpu writes; instruction select is ignored
    // cpu may write the flag
    if (I_CPU_WE && I_CPU_SEL == SDP_SEL_STATUS) begin
      n.flag = I_CPU_WDATA[SDP_FLAG_BIT];
    end
    // cpu access to both data halves
    if (I_CPU_WE && I_CPU_SEL == SDP_SEL_DATA_HI) begin
      data_d[SDP_DATA_W-1:SDP_REG_W] = I_CPU_WDATA;
    end
    if (I_CPU_WE && I_CPU_SEL == SDP_SEL_DATA_LO) begin
      data_d[SDP_REG_W-1:0] = I_CPU_WDATA;
    end
    if (tck_rise) begin
      // tap controller walk on mode select
      case (q.state)
        SDP_TLR: n.state = q.tms_s2 ? SDP_TLR : SDP_RTI;
        SDP_RTI: n.state = q.tms_s2 ? SDP_SEL_DR : SDP_RTI;
        SDP_SEL_DR: n.state = q.tms_s2 ? SDP_SEL_IR : SDP_CAP_DR;
        SDP_CAP_DR: n.state = q.tms_s2 ? SDP_EX1_DR : SDP_SH_DR;
        SDP_SH_DR: n.state = q.tms_s2 ? SDP_EX1_DR : SDP_SH_DR;
        SDP_EX1_DR: n.state = q.tms_s2 ? SDP_UPD_DR : SDP_PA_DR;
        SDP_PA_DR: n.state = q.tms_s2 ? SDP_EX2_DR : SDP_PA_DR;
        SDP_EX2_DR: n.state = q.tms_s2 ? SDP_UPD_DR : SDP_SH_DR;
        SDP_UPD_DR: n.state = q.tms_s2 ? SDP_SEL_DR : SDP_RTI;
        SDP_SEL_IR: n.state = q.tms_s2 ? SDP_TLR : SDP_CAP_IR;
        SDP_CAP_IR: n.state = q.tms_s2 ? SDP_EX1_IR : SDP_SH_IR;
        SDP_SH_IR: n.state = q.tms_s2 ? SDP_EX1_IR : SDP_SH_IR;
        SDP_EX1_IR: n.state = q.tms_s2 ? SDP_UPD_IR : SDP_PA_IR;
        SDP_PA_IR: n.state = q.tms_s2 ? SDP_EX2_IR : SDP_PA_IR;
        SDP_EX2_IR: n.state = q.tms_s2 ? SDP_UPD_IR : SDP_SH_IR;
        SDP_UPD_IR: n.state = q.tms_s2 ? SDP_SEL_DR : SDP_RTI;
        default: n.state = SDP_TLR;
      endcase
      // register actions on the current state
      case (q.state)
        SDP_SH_IR: begin
          // keep the last four bits, first bit ends in bit 0
          n.ir_sh = {q.tdi_s2, q.ir_sh[SDP_INSTR_W-1:1]};
        end
        SDP_UPD_IR: begin
          n.instr = q.ir_sh;
          if (q.ir_sh == SDP_INSTR_IRQ) begin
            n.irq = 1'b1;
          end
        end
        SDP_CAP_DR: begin
          // flag lands in first shift position
          n.stat_sh = status_word;
          n.bypass = 1'b0;
        end
        SDP_SH_DR: begin
          if (q.instr != SDP_INSTR_IRQ) begin
            n.bypass = q.tdi_s2;
          end else if (data_sel) begin
            // shifting keeps the latest 32 bits
            data_d = {q.tdi_s2, data_q[SDP_DATA_W-1:1]};
          end else begin
            n.stat_sh = {1'b0, q.stat_sh[SDP_REG_W-1:1]};
          end
        end
        SDP_UPD_DR: begin
          // transfer done, cpu owns data word
          if (data_sel) begin
            n.flag = 1'b0;
          end
        end
        default: begin
          n.bypass = q.bypass;
        end
      endcase
      // count mode-select-high rises for the reset check
      if (!q.tms_s2) begin
        n.tms_hi = 3'h0;
      end else if (q.tms_hi != SDP_TMS_RESET_CNT) begin
        n.tms_hi = q.tms_hi + 3'h1;
      end
      // test logic reset returns initial values
      if (n.state == SDP_TLR) begin
        n.instr = SDP_INSTR_RESET;
        n.flag = SDP_FLAG_RESET;
      end
      // drive only while a chain shifts out
      n.tdo_oe = (n.state == SDP_SH_DR);
      // output updates on test clock rise
      if (q.instr != SDP_INSTR_IRQ) begin
        n.tdo = n.bypass;
      end else if (data_sel) begin
        // output starts at low bit 0
        n.tdo = data_d[0];
      end else begin
        n.tdo = n.stat_sh[0];
      end
    end
  end

  // control state; both resets give initial values
  // instruction all ones, flag one
  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.state <= SDP_TLR;
      q.instr <= SDP_INSTR_RESET;
      q.flag <= SDP_FLAG_RESET;
    end else begin
      q <= n;
    end
  end

  // data word has no reset at all
  // never initialised
  always_ff @(posedge I_CORE_CLK) begin
    data_q <= data_d;
  end

  // outputs straight from flops
  assign O_TDO = q.tdo;
  assign O_TDO_OE = q.tdo_oe;
  assign O_IRQ = q.irq;
  assign O_CPU_RDATA = q.rdata;
  assign O_CPU_FLAG = q.flag;

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!rst_n);

  property p_tap_still;
    !tck_rise |=> $stable(q.state);
  endproperty
  a_tap_still: assert property (p_tap_still)
    else $error("tap state moved without test clock rise");

  property p_ir_shift;
    (q.state == SDP_SH_IR) && tck_rise
      |=> q.ir_sh[SDP_INSTR_W-1] == $past(q.tdi_s2);
  endproperty
  a_ir_shift: assert property (p_ir_shift)
    else $error("instruction shift lost input bit");

  property p_oe_shift;
    q.tdo_oe |-> q.state == SDP_SH_DR;
  endproperty
  a_oe_shift: assert property (p_oe_shift)
    else $error("serial output driven outside shift");

  property p_instr_ro;
    I_CPU_WE && (I_CPU_SEL == SDP_SEL_INSTR) && !tck_rise
      |=> $stable(q.instr);
  endproperty
  a_instr_ro: assert property (p_instr_ro)
    else $error("cpu changed instruction register");

  property p_status_fixed;
    I_CPU_SEL == SDP_SEL_STATUS
      |=> O_CPU_RDATA[SDP_REG_W-1:1] == SDP_STAT_FIXED;
  endproperty
  a_status_fixed: assert property (p_status_fixed)
    else $error("status reserved bits wrong");

  property p_flag_clear;
    (q.state == SDP_UPD_DR) && tck_rise && data_sel
      && (n.state != SDP_TLR) |=> !q.flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("flag not cleared after data transfer");

  property p_data_first;
    (q.state == SDP_SH_DR) && tck_rise && data_sel
      |=> data_q[SDP_DATA_W-1] == $past(q.tdi_s2) ##0 O_TDO == data_q[0];
  endproperty
  a_data_first: assert property (p_data_first)
    else $error("data word shift order wrong");

  property p_irq;
    (q.state == SDP_UPD_IR) && tck_rise && (q.ir_sh == SDP_INSTR_IRQ)
      |=> O_IRQ ##1 !O_IRQ;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt request missing or too long");

  property p_bypass;
    (q.state == SDP_SH_DR) && tck_rise && (q.instr == SDP_INSTR_BYPASS)
      |=> O_TDO == $past(q.tdi_s2);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass stage did not pass input");

  property p_tms_reset;
    q.tms_hi == SDP_TMS_RESET_CNT |-> q.state == SDP_TLR;
  endproperty
  a_tms_reset: assert property (p_tms_reset)
    else $error("five mode-select-high edges did not reset");

  property p_status_in;
    (q.state == SDP_SH_DR) && tck_rise && !data_sel
      && (q.instr == SDP_INSTR_IRQ) |=> !q.stat_sh[SDP_REG_W-1];
  endproperty
  a_status_in: assert property (p_status_in)
    else $error("status loaded from serial input");

  property p_tdo_hold;
    !tck_rise |=> $stable(O_TDO) && $stable(O_TDO_OE);
  endproperty
  a_tdo_hold: assert property (p_tdo_hold)
    else $error("serial output moved without test clock rise");

  property p_irq_code;
    O_IRQ |-> q.instr == SDP_INSTR_IRQ;
  endproperty
  a_irq_code: assert property (p_irq_code)
    else $error("interrupt request under another instruction");

  property p_tlr_instr;
    q.state == SDP_TLR |-> q.instr == SDP_INSTR_RESET;
  endproperty
  a_tlr_instr: assert property (p_tlr_instr)
    else $error("instruction not initial in reset state");

  c_irq: cover property (O_IRQ);
  c_flag_clear: cover property (q.flag ##1 !q.flag);
  c_bypass_shift: cover property (q.tdo_oe && (q.instr == SDP_INSTR_BYPASS));
  c_data_shift: cover property (q.tdo_oe && data_sel);
  c_tms_reset: cover property (q.tms_hi == SDP_TMS_RESET_CNT);
endmodule : sdp_debug_port

// ==== tb/sdp_dbg_model.sv ====
`timescale 1ns/100ps
module sdp_dbg_model (
  input wire logic i_clk,
  input wire logic i_tdo,
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  output logic o_trst_n
);
  // pins idle, test clock stands low
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
    o_trst_n = 1'b1;
  end
  // one 160 ns test clock period, line read at the fall
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    @(negedge i_clk);
    o_tms = tms;
    o_tdi = tdi;
    repeat (15) @(negedge i_clk);
    o_tck = 1'b1;
    repeat (16) @(negedge i_clk);
    o_tck = 1'b0;
    tdo = i_tdo;
  endtask : tick
  // mode walk, lsb first; unused data line toggles
  task automatic seq(input logic [15:0] tms, input int n, output logic tdo);
    for (int i = 0; i < n; i++) tick(tms[i], ~o_tdi, tdo);
  endtask : seq
  task automatic shift(input logic ir, input int n, input logic [63:0] din,
                       output logic [63:0] dout);
    logic d;
    dout = '0;
    seq(ir ? 16'h0003 : 16'h0001, ir ? 4 : 3, d);
    dout[0] = d;
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], d);
      dout[i + 1] = d;
    end
    seq(16'h0001, 2, d);
  endtask : shift
  task automatic tms_reset();
    logic d;
    seq(16'h001F, 6, d);
  endtask : tms_reset
  // short test reset pulse
  task automatic trst_pulse();
    @(negedge i_clk);
    o_trst_n = 1'b0;
    repeat (4) @(negedge i_clk);
    o_trst_n = 1'b1;
  endtask : trst_pulse
endmodule : sdp_dbg_model

// ==== tb/serial_debug_data_port_tb.sv ====
`timescale 1ns/100ps
module serial_debug_data_port_tb;
  import sdp_pkg::*;
  logic clk, rst_n, tck, tms, tdi, trst_n, tdo, tdo_oe, irq, we, flag;
  logic rd_req, rd_seen, b;
  logic [1:0] sel;
  logic [15:0] wdata, rdata;
  logic [15:0] exp_q[$];
  int err_count = 0;
  int checks = 0;
  int irq_n = 0;
  int oe_n = 0;
  sdp_debug_port u_dut (.I_CORE_CLK(clk), .I_RSTN(rst_n), .I_TRST_N(trst_n),
    .I_TCK(tck), .I_TMS(tms), .I_TDI(tdi), .O_TDO(tdo), .O_TDO_OE(tdo_oe),
    .O_IRQ(irq), .I_CPU_SEL(sel), .I_CPU_WE(we), .I_CPU_WDATA(wdata),
    .O_CPU_RDATA(rdata), .O_CPU_FLAG(flag));
  // released output line floats high
  sdp_dbg_model u_dbg (.i_clk(clk), .i_tdo(tdo_oe ? tdo : 1'b1),
    .o_tck(tck), .o_tms(tms), .o_tdi(tdi), .o_trst_n(trst_n));
  // core clock 200 MHz
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic fail(input string m);
    err_count++;
    $display("[FAIL] %0t %s", $time, m);
  endtask : fail
  task automatic chk(input logic [63:0] g, input logic [63:0] e, string m);
    checks++;
    if (g !== e) fail(m);
  endtask : chk
  task automatic conclude();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  task automatic wr(input logic [1:0] s, input logic [15:0] d);
    @(negedge clk);
    sel = s;
    wdata = d;
    we = 1'b1;
    @(negedge clk);
    we = 1'b0;
  endtask : wr
  // read request, expected value noted for the monitor
  task automatic rd(input logic [1:0] s, input logic [15:0] e);
    @(negedge clk);
    sel = s;
    rd_req = 1'b1;
    exp_q.push_back(e);
    @(negedge clk);
    rd_req = 1'b0;
    @(negedge clk);
  endtask : rd
  // monitor: read data compared a cycle after the request
  always @(posedge clk) rd_seen <= rd_req;
  always @(negedge clk) begin
    if (rd_seen) begin
      checks++;
      if (rdata !== exp_q.pop_front()) fail("cpu read data wrong");
    end
  end
  // interrupt pulses and output enable activity
  always @(posedge clk) begin
    if (irq === 1'b1) irq_n <= irq_n + 1;
    if (tdo_oe === 1'b1) oe_n <= oe_n + 1;
  end
  // watchdog
  initial begin
    #200000;
    fail("timeout");
    conclude();
  end
  initial begin
    logic [63:0] d, r, w;
    int oe0;
    rst_n = 1'b0;
    sel = '0;
    we = 1'b0;
    wdata = '0;
    rd_req = 1'b0;
    oe0 = 0;
    void'($urandom(32'h394DFD26));
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    rd(SDP_SEL_INSTR, 16'hF000);
    rd(SDP_SEL_STATUS, 16'h0801);
    chk(flag, 1'b1, "flag after reset");
    chk(tdo_oe, 1'b0, "output driven when idle");
    wr(SDP_SEL_INSTR, 16'h1234);
    rd(SDP_SEL_INSTR, 16'hF000);
    wr(SDP_SEL_STATUS, 16'hFFFE);
    rd(SDP_SEL_STATUS, 16'h0800);
    wr(SDP_SEL_STATUS, 16'h0001);
    w = {32'h0, $urandom};
    wr(SDP_SEL_DATA_HI, w[31:16]);
    wr(SDP_SEL_DATA_LO, w[15:0]);
    rd(SDP_SEL_DATA_HI, w[31:16]);
    rd(SDP_SEL_DATA_LO, w[15:0]);
    $display("test cpu registers done");
    u_dbg.seq(16'h0000, 1, b);
    oe0 = oe_n;
    u_dbg.shift(1'b1, 6, 64'h29, r);
    chk(oe_n - oe0, 0, "output driven in instruction shift");
    chk(irq_n, 1, "no interrupt pulse");
    rd(SDP_SEL_INSTR, 16'hA000);
    d = {$urandom, $urandom};
    u_dbg.shift(1'b0, 40, d, r);
    chk(r[31:0], w, "serial word out");
    chk(oe_n > oe0, 1'b1, "output not driven in data shift");
    chk(flag, 1'b0, "flag not cleared");
    rd(SDP_SEL_DATA_HI, d[39:24]);
    rd(SDP_SEL_DATA_LO, d[23:8]);
    u_dbg.shift(1'b0, 12, 64'hFFF, r);
    chk(r[11:0], 12'h800, "status shift");
    rd(SDP_SEL_STATUS, 16'h0800);
    $display("test serial transfer done");
    u_dbg.shift(1'b1, 4, 64'hF, r);
    rd(SDP_SEL_INSTR, 16'hF000);
    w = {32'h0, $urandom};
    u_dbg.shift(1'b0, 9, w, r);
    chk(r[8:1], w[7:0], "bypass path");
    $display("test bypass done");
    u_dbg.shift(1'b1, 4, 64'hA, r);
    wr(SDP_SEL_STATUS, 16'h0800);
    u_dbg.tms_reset();
    rd(SDP_SEL_INSTR, 16'hF000);
    chk(flag, 1'b1, "flag after mode reset");
    u_dbg.shift(1'b1, 4, 64'hA, r);
    u_dbg.trst_pulse();
    rd(SDP_SEL_INSTR, 16'hF000);
    rd(SDP_SEL_STATUS, 16'h0801);
    rd(SDP_SEL_DATA_HI, d[39:24]);
    rd(SDP_SEL_DATA_LO, d[23:8]);
    chk(irq_n, 3, "interrupt count");
    $display("test resets done");
    conclude();
  end
endmodule : serial_debug_data_port_tb
